// ---- design/lhbp_pkg.sv ----
// Package of constants and types shared by both ends of the LCD host port
// -----------------------------------------------------------------------
// -----------------------------------------------------------------------
package lhbp_pkg;
  localparam int DW = 8;
  localparam int NW = 4;
  localparam int PW = 7;
  localparam logic [5:0] SER_ADDR_FIXED = 6'h1d;
  localparam logic [PW-1:0] PTR_RESET = 7'h00;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [NW-1:0] NIB_ZERO = 4'h0;
  localparam logic [NW-1:0] NIB_ONES = 4'hf;
  localparam int BUSY_BIT = 7;
  localparam logic RSEL_INSTR = 1'b0;
  localparam logic RSEL_DATA = 1'b1;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam int INSTR_NS = 400;
  localparam int CLK_NS = 10;
  localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_NS = 250;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] BUSY_LOAD = 8'(INSTR_CYC);
  localparam logic [7:0] STB_LOAD = 8'(STROBE_CYC);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;

  typedef enum logic [4:0] {
    LHBP_IDLE  = 5'b00001,
    LHBP_SETUP = 5'b00010,
    LHBP_HIGH  = 5'b00100,
    LHBP_FALL  = 5'b01000,
    LHBP_DONE  = 5'b10000
  } lhbp_state_e;

  function automatic logic [6:0] lhbp_ser_addr(input logic sub);
    return {SER_ADDR_FIXED, sub};
  endfunction

  function automatic logic [NW-1:0] lhbp_nib(input logic [DW-1:0] b,
                                             input logic hi);
    return hi ? b[DW-1:NW] : b[NW-1:0];
  endfunction
endpackage

// ---- design/lhbp_if.sv ----
// Parallel pin bundle joining the LCD device end and the host end
`timescale 1ns/1ps
`default_nettype none
interface lhbp_if;
  logic reg_choose;
  logic dir_read;
  logic strobe;
  logic [7:0] host_lines_out;
  logic [7:0] host_lines_oe_n;
  logic [7:0] dev_lines_out;
  logic [7:0] dev_lines_oe_n;
  logic reg_choose_drv_n;
  logic dir_drv_n;
  logic [7:0] host_data_lines;
  logic reg_choose_pin;
  logic dir_pin;
  // Weak pull-ups: an undriven line reads high
  genvar g;
  for (g = 0; g < 8; g++) begin : g_line
    assign host_data_lines[g] = !dev_lines_oe_n[g] ? dev_lines_out[g] :
                                !host_lines_oe_n[g] ? host_lines_out[g] :
                                1'b1;
  end
  assign reg_choose_pin = reg_choose_drv_n ? 1'b1 : reg_choose;
  assign dir_pin = dir_drv_n ? 1'b1 : dir_read;
  modport dev (input reg_choose_pin, input dir_pin, input strobe,
               input host_data_lines, output dev_lines_out,
               output dev_lines_oe_n);
  modport host (output reg_choose, output dir_read, output strobe,
                output host_lines_out, output host_lines_oe_n,
                output reg_choose_drv_n, output dir_drv_n,
                input host_data_lines);
endinterface
`default_nettype wire

// ---- design/lhbp_device.sv ----
// Device end: parallel register port of the LCD controller
`timescale 1ns/1ps
`default_nettype none
module lhbp_device (
  input wire logic MCLK,
  input wire logic RESET,
  lhbp_if.dev BUS,
  input wire logic NARROW,
  input wire logic SUBADDR_PIN,
  input wire logic [7:0] RAM_RDATA,
  output logic [6:0] RAM_PTR,
  output logic [6:0] SER_ADDR,
  output logic [7:0] INSTR_OUT,
  output logic INSTR_VALID,
  output logic [7:0] DATA_OUT,
  output logic DATA_VALID,
  input wire logic DONE
);
  import lhbp_pkg::*;

  typedef struct packed {
    logic [2:0] e_sync;
    logic [2:0] rs_sync;
    logic [2:0] rw_sync;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic [7:0] d_s3;
    logic e_state;
    logic lo_half;
    logic [7:0] hold;
    logic [7:0] instr_reg;
    logic [7:0] data_hold_reg;
    logic [6:0] ram_pointer;
    logic busy;
    logic drive;
    logic [7:0] dout;
    logic ivalid;
    logic dvalid;
    logic [2:0] sub_sync;
  } lhbp_dev_s;

  lhbp_dev_s r;
  lhbp_dev_s next_r;
  logic e_now;
  logic rs_now;
  logic rw_now;
  logic [7:0] d_now;
  logic e_fall;
  logic [7:0] status;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;

  always_comb begin
    next_r = r;
    next_r.e_sync = {r.e_sync[1:0], BUS.strobe};
    next_r.rs_sync = {r.rs_sync[1:0], BUS.reg_choose_pin};
    next_r.rw_sync = {r.rw_sync[1:0], BUS.dir_pin};
    next_r.sub_sync = {r.sub_sync[1:0], SUBADDR_PIN};
    next_r.d_s1 = BUS.host_data_lines;
    next_r.d_s2 = r.d_s1;
    next_r.d_s3 = r.d_s2;
    next_r.ivalid = 1'b0;
    next_r.dvalid = 1'b0;
    // A level counts once stages two and three agree
    e_now = (r.e_sync[1] == r.e_sync[2]) ? r.e_sync[2] : r.e_state;
    rs_now = r.rs_sync[2];
    rw_now = r.rw_sync[2];
    d_now = r.d_s3;
    next_r.e_state = e_now;
    e_fall = r.e_state && !e_now;
    // Status: busy on top line, pointer below
    status = {r.busy, r.ram_pointer};
    // Instruction register never read back
    rd_byte = (rs_now == RSEL_INSTR) ? status : r.data_hold_reg;
    // Drive read data while strobe high, release on fall
    if (e_now && rw_now == DIR_READ) begin
      next_r.drive = 1'b1;
      if (!r.drive) begin
        next_r.dout = rd_byte;
      end
    end else begin
      next_r.drive = 1'b0;
    end
    // Narrow mode: upper lines carry high nibble then low
    if (NARROW && r.lo_half) begin
      next_r.dout = {lhbp_nib(rd_byte, 1'b0), NIB_ONES};
    end
    if (e_fall) begin
      if (NARROW) begin
        next_r.lo_half = !r.lo_half;
        if (!r.lo_half) begin
          next_r.hold = {d_now[7:4], NIB_ZERO};
        end
      end
      wr_byte = NARROW ? {r.hold[7:4], d_now[7:4]} : d_now;
      if (!NARROW || r.lo_half) begin
        if (rw_now == DIR_WRITE && rs_now == RSEL_INSTR && !r.busy) begin
          next_r.instr_reg = wr_byte;
          next_r.ivalid = 1'b1;
          next_r.busy = 1'b1;
        end else if (rw_now == DIR_WRITE && rs_now == RSEL_DATA) begin
          next_r.data_hold_reg = wr_byte;
          next_r.dvalid = 1'b1;
          next_r.ram_pointer = r.ram_pointer + 7'h01;
        end else if (rw_now == DIR_READ && rs_now == RSEL_DATA) begin
          next_r.ram_pointer = r.ram_pointer + 7'h01;
        end
      end
    end else begin
      wr_byte = BYTE_ZERO;
    end
    // Preload data register from RAM at pointer
    // A fresh host write stands for two cycles before the reload
    if (!(e_now && rw_now == DIR_READ && rs_now == RSEL_DATA) &&
        !next_r.dvalid) begin
      next_r.data_hold_reg = r.dvalid ? r.data_hold_reg : RAM_RDATA;
    end
    if (DONE) begin
      next_r.busy = 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Narrow mode never drives the lower four lines
  assign BUS.dev_lines_out = r.dout;
  assign BUS.dev_lines_oe_n = r.drive ? (NARROW ? 8'h0f : 8'h00) : 8'hff;
  assign RAM_PTR = r.ram_pointer;
  assign SER_ADDR = lhbp_ser_addr(r.sub_sync[2]);
  assign INSTR_OUT = r.instr_reg;
  assign INSTR_VALID = r.ivalid;
  assign DATA_OUT = r.data_hold_reg;
  assign DATA_VALID = r.dvalid;
endmodule
`default_nettype wire

// ---- design/lhbp_host.sv ----
// Host end: drives parallel cycles toward the LCD controller
`timescale 1ns/1ps
`default_nettype none
module lhbp_host #(
  parameter int STB_CYC = lhbp_pkg::STROBE_CYC
) (
  input wire logic MCLK,
  input wire logic RESET,
  lhbp_if.host BUS,
  input wire logic NARROW,
  input wire logic SERIAL_MODE,
  input wire logic REQ,
  input wire logic REQ_RS,
  input wire logic REQ_READ,
  input wire logic [7:0] REQ_DATA,
  output logic READY,
  output logic [7:0] RDATA,
  output logic RVALID
);
  import lhbp_pkg::*;

  typedef struct packed {
    lhbp_state_e st;
    logic [7:0] cnt;
    logic rs;
    logic rd;
    logic [7:0] wdata;
    logic lo_half;
    logic strobe;
    logic [7:0] rdata;
    logic rvalid;
  } lhbp_host_s;

  lhbp_host_s r;
  lhbp_host_s next_r;

  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    case (r.st)
      LHBP_IDLE: begin
        if (REQ && !SERIAL_MODE) begin
          next_r.rs = REQ_RS;
          next_r.rd = REQ_READ;
          next_r.wdata = REQ_DATA;
          next_r.lo_half = 1'b0;
          next_r.cnt = STB_CYC[7:0];
          next_r.st = LHBP_SETUP;
        end
      end
      LHBP_SETUP: begin
        next_r.strobe = 1'b1;
        next_r.cnt = STB_CYC[7:0];
        next_r.st = LHBP_HIGH;
      end
      LHBP_HIGH: begin
        if (r.cnt == CNT_ONE) begin
          next_r.strobe = 1'b0;
          next_r.cnt = CNT_ONE;
          next_r.st = LHBP_FALL;
          if (r.rd && NARROW) begin
            next_r.rdata = r.lo_half ?
              {r.rdata[7:4], BUS.host_data_lines[7:4]} :
              {BUS.host_data_lines[7:4], NIB_ZERO};
          end else if (r.rd) begin
            next_r.rdata = BUS.host_data_lines;
          end
        end else begin
          next_r.cnt = r.cnt - CNT_ONE;
        end
      end
      LHBP_FALL: begin
        if (r.cnt != CNT_ZERO) begin
          // Keep strobe low long enough for the far synchroniser
          next_r.cnt = r.cnt - CNT_ONE;
        end else if (NARROW && !r.lo_half) begin
          next_r.lo_half = 1'b1;
          next_r.st = LHBP_SETUP;
        end else begin
          next_r.st = LHBP_DONE;
        end
      end
      LHBP_DONE: begin
        next_r.rvalid = r.rd;
        next_r.st = LHBP_IDLE;
      end
      default: begin
        next_r.st = LHBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      r <= '{st: LHBP_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Serial mode: strobe low, all lines released
  assign BUS.strobe = SERIAL_MODE ? 1'b0 : r.strobe;
  assign BUS.reg_choose = r.rs;
  assign BUS.dir_read = r.rd;
  assign BUS.reg_choose_drv_n = SERIAL_MODE;
  assign BUS.dir_drv_n = SERIAL_MODE;
  assign BUS.host_lines_out = (NARROW && r.lo_half) ?
    {lhbp_nib(r.wdata, 1'b0), NIB_ONES} : r.wdata;
  assign BUS.host_lines_oe_n = (SERIAL_MODE || r.rd ||
    r.st == LHBP_IDLE) ? 8'hff : (NARROW ? 8'h0f : 8'h00);
  assign READY = (r.st == LHBP_IDLE) && !SERIAL_MODE;
  assign RDATA = r.rdata;
  assign RVALID = r.rvalid;
endmodule
`default_nettype wire

// ---- test/lhbp_checker.sv ----
// Pin-level protocol checker between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module lhbp_checker #(
  parameter int STB_CYC = 6
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic strobe,
  input wire logic dir_read,
  input wire logic reg_choose,
  input wire logic reg_choose_drv_n,
  input wire logic [7:0] host_lines_out,
  input wire logic [7:0] host_lines_oe_n,
  input wire logic [7:0] dev_lines_oe_n,
  input wire logic [7:0] host_data_lines,
  input wire logic dir_pin
);
  logic [7:0] hi_cnt;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // Length of the strobe pulse now in progress
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= strobe ? hi_cnt + 8'h01 : 8'h00;
  end
  a_strobe_width: assert property ($fell(strobe) |-> hi_cnt == 8'(STB_CYC))
    else $error("strobe pulse width wrong");
  a_strobe_gap: assert property ($fell(strobe) |=> !strobe [*2])
    else $error("strobe raised again too soon");
  a_ctrl_hold: assert property (strobe && $past(strobe) |->
    $stable(reg_choose) && $stable(dir_read))
    else $error("select or direction moved under strobe");
  a_wdata_hold: assert property (strobe && $past(strobe) && !dir_read |->
    $stable(host_lines_out))
    else $error("write data moved under strobe");
  a_read_release: assert property (strobe && dir_read |->
    host_lines_oe_n == 8'hff)
    else $error("host drives lines during read");
  a_dev_drive: assert property ($fell(dev_lines_oe_n[7]) |-> dir_pin && strobe)
    else $error("device drives lines outside a read");
  a_no_clash: assert property ((~dev_lines_oe_n & ~host_lines_oe_n) == 8'h00)
    else $error("both ends drive the lines");
  a_pull_high: assert property (&dev_lines_oe_n && &host_lines_oe_n |->
    host_data_lines == 8'hff)
    else $error("released lines not high");
  a_low_nibble: assert property (dev_lines_oe_n[3:0] != 4'hf |->
    dev_lines_oe_n[7:4] == 4'h0)
    else $error("lower lines driven without upper");
  a_serial_quiet: assert property (reg_choose_drv_n |->
    !strobe && &host_lines_oe_n)
    else $error("parallel pins active in serial mode");
  c_read: cover property ($fell(strobe) && dir_read);
  c_write: cover property ($fell(strobe) && !dir_read);
  c_serial: cover property ($rose(reg_choose_drv_n));
endmodule
`default_nettype wire

// ---- test/lcd_host_bus_port_tb.sv ----
// Bench joining host and device ends back to back
`timescale 1ns/1ps
`default_nettype none
module lcd_host_bus_port_tb;
  import lhbp_pkg::*;
  localparam int STB = 6;
  logic MCLK, RESET, NARROW, SERIAL_MODE, SUBADDR_PIN, DONE;
  logic REQ, REQ_RS, REQ_READ, READY, RVALID, INSTR_VALID, DATA_VALID;
  logic [7:0] REQ_DATA, RDATA, RAM_RDATA, INSTR_OUT, DATA_OUT, q;
  logic [6:0] RAM_PTR, SER_ADDR;
  logic [7:0] dlast;
  int error_cnt = 0, cmp_count = 0, cyc = 0, ic = 0, dc = 0;
  lhbp_if bus ();
  // RAM image: each word derived from its address
  assign RAM_RDATA = {1'b0, RAM_PTR} ^ 8'hc3;
  lhbp_device u_lhbp_device (.MCLK(MCLK), .RESET(RESET), .BUS(bus.dev),
    .NARROW(NARROW), .SUBADDR_PIN(SUBADDR_PIN), .RAM_RDATA(RAM_RDATA),
    .RAM_PTR(RAM_PTR), .SER_ADDR(SER_ADDR), .INSTR_OUT(INSTR_OUT),
    .INSTR_VALID(INSTR_VALID), .DATA_OUT(DATA_OUT),
    .DATA_VALID(DATA_VALID), .DONE(DONE));
  lhbp_host #(.STB_CYC(STB)) u_lhbp_host (.MCLK(MCLK), .RESET(RESET),
    .BUS(bus.host), .NARROW(NARROW), .SERIAL_MODE(SERIAL_MODE), .REQ(REQ),
    .REQ_RS(REQ_RS), .REQ_READ(REQ_READ), .REQ_DATA(REQ_DATA),
    .READY(READY), .RDATA(RDATA), .RVALID(RVALID));
  lhbp_checker #(.STB_CYC(STB)) u_chk (.MCLK(MCLK), .RESET(RESET),
    .strobe(bus.strobe), .dir_read(bus.dir_read),
    .reg_choose(bus.reg_choose), .reg_choose_drv_n(bus.reg_choose_drv_n),
    .host_lines_out(bus.host_lines_out),
    .host_lines_oe_n(bus.host_lines_oe_n),
    .dev_lines_oe_n(bus.dev_lines_oe_n),
    .host_data_lines(bus.host_data_lines), .dir_pin(bus.dir_pin));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // Cycle ceiling and counts of device write pulses
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (INSTR_VALID === 1'b1) ic <= ic + 1;
    if (DATA_VALID === 1'b1) dc <= dc + 1;
    if (DATA_VALID === 1'b1) dlast <= DATA_OUT;
    if (cyc == 20000) begin
      error_cnt++;
      conclude;
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One host request, waits until the host is idle again
  task automatic xfer(input logic rs, rd, input logic [7:0] d);
    int n;
    n = 0;
    q = 8'hxx;
    while (READY !== 1'b1 && n < 400) begin
      @(negedge MCLK);
      n++;
    end
    @(posedge MCLK);
    REQ <= 1'b1;
    REQ_RS <= rs;
    REQ_READ <= rd;
    REQ_DATA <= d;
    @(posedge MCLK);
    REQ <= 1'b0;
    @(negedge MCLK);
    while (READY !== 1'b1 && n < 400) begin
      if (RVALID === 1'b1) q = RDATA;
      @(negedge MCLK);
      n++;
    end
    if (RVALID === 1'b1) q = RDATA;
    repeat (6) @(negedge MCLK);
    chk("handshake", {7'h00, n < 400}, 8'h01);
  endtask
  task automatic st(input logic [7:0] e);
    xfer(RSEL_INSTR, DIR_READ, 8'h00);
    chk("status", q, e);
  endtask
  task automatic clear_busy;
    @(posedge MCLK);
    DONE <= 1'b1;
    @(posedge MCLK);
    DONE <= 1'b0;
    repeat (2) @(negedge MCLK);
  endtask
  initial begin
    RESET = 1'b1;
    {NARROW, SERIAL_MODE, SUBADDR_PIN, DONE, REQ, REQ_RS, REQ_READ} = '0;
    REQ_DATA = 8'h00;
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      @(posedge MCLK);
      SUBADDR_PIN <= s[0];
      repeat (5) @(negedge MCLK);
      chk("bus address", {1'b0, SER_ADDR}, {1'b0, 6'h1d, s[0]});
    end
    for (int w = 0; w < 2; w++) begin
      @(posedge MCLK);
      NARROW <= w[0];
      st({1'b0, 7'(3 * w)});
      xfer(RSEL_INSTR, DIR_WRITE, 8'h38 ^ 8'(w));
      chk("instr", INSTR_OUT, 8'h38 ^ 8'(w));
      st({1'b1, 7'(3 * w)});
      xfer(RSEL_INSTR, DIR_WRITE, 8'h01);
      chk("instr refused", 8'(ic), 8'(w + 1));
      clear_busy;
      st({1'b0, 7'(3 * w)});
      xfer(RSEL_DATA, DIR_WRITE, 8'ha5 ^ 8'(w));
      chk("data", dlast, 8'ha5 ^ 8'(w));
      chk("data pulses", 8'(dc), 8'(2 * w + 1));
      xfer(RSEL_DATA, DIR_READ, 8'h00);
      chk("ram read", q, 8'(3 * w + 1) ^ 8'hc3);
      st({1'b0, 7'(3 * w + 2)});
      xfer(RSEL_DATA, DIR_WRITE, 8'h00);
    end
    @(posedge MCLK);
    SERIAL_MODE <= 1'b1;
    repeat (4) @(negedge MCLK);
    chk("serial pins", {READY, bus.strobe, bus.reg_choose_pin, bus.dir_pin,
      bus.host_data_lines[3:0]}, 8'h3f);
    chk("serial lines", bus.host_data_lines, 8'hff);
    conclude;
  end
endmodule
`default_nettype wire
